// ==== verilog/tca_pkg.sv ====
// Purpose: constants for the 16-bit timer counter and compare access block
// Assumes: byte-wide processor I/O bus, 100 MHz core clock
// Notes: counter locations are placed beside their compare groups
package tca_pkg;
  localparam logic [7:0] ADDR_CMP_T1_A_LOW = 8'h88;
  localparam logic [7:0] ADDR_CMP_T1_A_HIGH = 8'h89;
  localparam logic [7:0] ADDR_CMP_T1_B_LOW = 8'h8A;
  localparam logic [7:0] ADDR_CMP_T1_B_HIGH = 8'h8B;
  localparam logic [7:0] ADDR_CMP_T1_C_LOW = 8'h8C;
  localparam logic [7:0] ADDR_CMP_T1_C_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CMP_T3_A_LOW = 8'h98;
  localparam logic [7:0] ADDR_CMP_T3_A_HIGH = 8'h99;
  localparam logic [7:0] ADDR_CMP_T3_B_LOW = 8'h9A;
  localparam logic [7:0] ADDR_CMP_T3_B_HIGH = 8'h9B;
  localparam logic [7:0] ADDR_CMP_T3_C_LOW = 8'h9C;
  localparam logic [7:0] ADDR_CMP_T3_C_HIGH = 8'h9D;
  localparam logic [7:0] ADDR_CMP_T4_A_LOW = 8'hA8;
  localparam logic [7:0] ADDR_CMP_T4_A_HIGH = 8'hA9;
  localparam logic [7:0] ADDR_CMP_T4_B_HIGH = 8'hAA;
  localparam logic [7:0] ADDR_CMP_T4_B_LOW = 8'hAB;
  localparam logic [7:0] ADDR_COUNTER_T1_LOW = 8'h84;
  localparam logic [7:0] ADDR_COUNTER_T1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_COUNTER_T3_LOW = 8'h94;
  localparam logic [7:0] ADDR_COUNTER_T3_HIGH = 8'h95;
  localparam logic [7:0] ADDR_COUNTER_T4_LOW = 8'hA4;
  localparam logic [7:0] ADDR_COUNTER_T4_HIGH = 8'hA5;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int NUM_COMPARE = 8;
  localparam int NUM_TIMERS = 3;
endpackage

// ==== verilog/tca_timer_unit.sv ====
// Purpose: one 16-bit counter with its compare channels
// Assumes: tick_in is a one-cycle timer clock enable
// Notes: a load wins over a tick in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tca_timer_unit
  import tca_pkg::*;
#(
  parameter int NCH = 3
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic [15:0] load_value_in,
  input wire logic [NCH-1:0][15:0] compare_value_in,
  output logic [15:0] counter_value_out,
  output logic [NCH-1:0] match_out
);
  logic blocked;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      counter_value_out <= COUNTER_RESET;
    end else if (load_in) begin
      counter_value_out <= load_value_in;
    end else if (tick_in) begin
      counter_value_out <= counter_value_out + 16'h0001;
    end
  end

  // a counter write masks the compare on the next tick
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      blocked <= 1'b0;
    end else if (load_in) begin
      blocked <= 1'b1; // see [RQ5]
    end else if (tick_in) begin
      blocked <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      match_out <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // see [RQ9] see [RQ5]
        match_out[i] <= tick_in && !load_in && !blocked
                        && (counter_value_out == compare_value_in[i]);
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/tca_access.sv ====
// Purpose: byte-wide I/O access to 16-bit counters and compare values
// Assumes: one I/O access per cycle, read and write never together
// Notes: read data appear one cycle after the read strobe
//   a lone low write commits whatever the latch holds
//   compare reads bypass the latch, counter reads go through it
//   any high write, counter or compare, overwrites the one latch
// What this block does
// [RQ1] software writes zeros to control C bits 4:0
// [RQ2] counter readable and writable as two bytes
// [RQ3] counter access goes through high-byte latch
// [RQ4] one latch shared by all 16-bit registers
// [RQ5] counter write blocks next tick's compare match
// [RQ6] software avoids writing a running counter
// [RQ7] timer 1 A compare at 0x89/0x88, reset zero
// [RQ8] timer 4 B compare high 0xAA, low 0xAB
// [RQ9] compare values constantly matched against counter
// [RQ10] high write latches, low write commits both
`timescale 1ns/1ps
`default_nettype none
module tca_access
  import tca_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_write_in,
  input wire logic io_read_in,
  input wire logic [NUM_TIMERS-1:0] tick_in,
  output logic [7:0] io_rdata_out,
  output logic [7:0] match_out
);
  logic [7:0] temp_high;
  logic [15:0] compare_value [NUM_COMPARE];
  logic [15:0] counter_t1;
  logic [15:0] counter_t3;
  logic [15:0] counter_t4;
  logic [15:0] counter_sel;
  logic [NUM_TIMERS-1:0] counter_load;
  logic [2:0] match_t1;
  logic [2:0] match_t3;
  logic [1:0] match_t4;

  // compare decode: {hit, is_high, index}
  function automatic logic [4:0] cmp_decode(input logic [7:0] a);
    case (a)
      ADDR_CMP_T1_A_LOW: cmp_decode = 5'h10;
      ADDR_CMP_T1_A_HIGH: cmp_decode = 5'h18;
      ADDR_CMP_T1_B_LOW: cmp_decode = 5'h11;
      ADDR_CMP_T1_B_HIGH: cmp_decode = 5'h19;
      ADDR_CMP_T1_C_LOW: cmp_decode = 5'h12;
      ADDR_CMP_T1_C_HIGH: cmp_decode = 5'h1A;
      ADDR_CMP_T3_A_LOW: cmp_decode = 5'h13;
      ADDR_CMP_T3_A_HIGH: cmp_decode = 5'h1B;
      ADDR_CMP_T3_B_LOW: cmp_decode = 5'h14;
      ADDR_CMP_T3_B_HIGH: cmp_decode = 5'h1C;
      ADDR_CMP_T3_C_LOW: cmp_decode = 5'h15;
      ADDR_CMP_T3_C_HIGH: cmp_decode = 5'h1D;
      ADDR_CMP_T4_A_LOW: cmp_decode = 5'h16;
      ADDR_CMP_T4_A_HIGH: cmp_decode = 5'h1E;
      ADDR_CMP_T4_B_HIGH: cmp_decode = 5'h1F; // see [RQ8]
      ADDR_CMP_T4_B_LOW: cmp_decode = 5'h17; // see [RQ8]
      default: cmp_decode = 5'h00;
    endcase
  endfunction

  // counter decode: {hit, is_high, timer index}
  function automatic logic [3:0] cnt_decode(input logic [7:0] a);
    case (a)
      ADDR_COUNTER_T1_LOW: cnt_decode = 4'h8;
      ADDR_COUNTER_T1_HIGH: cnt_decode = 4'hC;
      ADDR_COUNTER_T3_LOW: cnt_decode = 4'h9;
      ADDR_COUNTER_T3_HIGH: cnt_decode = 4'hD;
      ADDR_COUNTER_T4_LOW: cnt_decode = 4'hA;
      ADDR_COUNTER_T4_HIGH: cnt_decode = 4'hE;
      default: cnt_decode = 4'h0;
    endcase
  endfunction

  logic [4:0] cmp_dec;
  logic [3:0] cnt_dec;
  logic [2:0] cmp_idx;
  logic [1:0] cnt_idx;
  assign cmp_dec = cmp_decode(io_addr_in);
  assign cnt_dec = cnt_decode(io_addr_in);
  assign cmp_idx = cmp_dec[2:0];
  assign cnt_idx = cnt_dec[1:0];

  // decoded fields of the current access
  logic cmp_hit;
  logic cmp_high;
  logic cnt_hit;
  logic cnt_high;
  assign cmp_hit = cmp_dec[4];
  assign cmp_high = cmp_dec[3];
  assign cnt_hit = cnt_dec[3];
  assign cnt_high = cnt_dec[2];

  // access strobes; a high write of any kind lands in the one latch
  logic latch_load;
  logic latch_capture;
  logic cmp_commit;
  logic cnt_commit;
  assign latch_load = io_write_in && ((cmp_hit && cmp_high) || (cnt_hit && cnt_high));
  assign latch_capture = io_read_in && cnt_hit && !cnt_high;
  assign cmp_commit = io_write_in && cmp_hit && !cmp_high;
  assign cnt_commit = io_write_in && cnt_hit && !cnt_high;

  // the 16-bit word that a low write commits
  logic [15:0] commit_word;
  assign commit_word = {temp_high, io_wdata_in};

  // counter of the addressed timer
  always_comb begin
    case (cnt_idx)
      2'h0: counter_sel = counter_t1;
      2'h1: counter_sel = counter_t3;
      2'h2: counter_sel = counter_t4;
      default: counter_sel = COUNTER_RESET;
    endcase
  end

  // shared high-byte latch
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      temp_high <= TEMP_RESET;
    end else if (latch_load) begin
      temp_high <= io_wdata_in; // see [RQ4] see [RQ10]
    end else if (latch_capture) begin
      // low read freezes the high half for the following high read
      temp_high <= counter_sel[15:8]; // see [RQ3] see [RQ10]
    end
  end

  // low-byte write commits both halves of a compare value
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_COMPARE; i++) begin
        compare_value[i] <= COMPARE_RESET; // see [RQ7] see [RQ8]
      end
    end else if (cmp_commit) begin
      compare_value[cmp_idx] <= commit_word; // see [RQ10] see [RQ7]
    end
  end

  // low-byte write loads the whole counter at once
  // the unit lets this load win over a tick in the same cycle
  always_comb begin
    counter_load = '0;
    if (cnt_commit) begin
      counter_load[cnt_idx] = 1'b1; // see [RQ2] see [RQ3]
    end
  end

  // half of a 16-bit word chosen by the high flag
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic high);
    pick_byte = high ? w[15:8] : w[7:0];
  endfunction

  // read data of the current strobe; the flop holds it until the next read
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (cnt_hit) begin
      // high half comes from the latch
      next_rdata = cnt_high ? temp_high : counter_sel[7:0]; // see [RQ2] see [RQ3]
    end else if (cmp_hit) begin
      next_rdata = pick_byte(compare_value[cmp_idx], cmp_high);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      io_rdata_out <= UNMAPPED_READ;
    end else if (io_read_in) begin
      io_rdata_out <= next_rdata;
    end
  end

  // compare values grouped by the timer that watches them
  logic [2:0][15:0] compare_t1;
  logic [2:0][15:0] compare_t3;
  logic [1:0][15:0] compare_t4;
  assign compare_t1 = {compare_value[2], compare_value[1], compare_value[0]};
  assign compare_t3 = {compare_value[5], compare_value[4], compare_value[3]};
  assign compare_t4 = {compare_value[7], compare_value[6]};

  // timer 1: channels A to C, match bits 2:0
  tca_timer_unit #(.NCH(3)) u_timer1 (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(tick_in[0]),
    .load_in(counter_load[0]),
    .load_value_in(commit_word),
    .compare_value_in(compare_t1),
    .counter_value_out(counter_t1),
    .match_out(match_t1)
  );

  // timer 3: channels A to C, match bits 5:3
  tca_timer_unit #(.NCH(3)) u_timer3 (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(tick_in[1]),
    .load_in(counter_load[1]),
    .load_value_in(commit_word),
    .compare_value_in(compare_t3),
    .counter_value_out(counter_t3),
    .match_out(match_t3)
  );

  // timer 4: channels A and B only, match bits 7:6
  tca_timer_unit #(.NCH(2)) u_timer4 (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(tick_in[2]),
    .load_in(counter_load[2]),
    .load_value_in(commit_word),
    .compare_value_in(compare_t4),
    .counter_value_out(counter_t4),
    .match_out(match_t4)
  );

  assign match_out = {match_t4, match_t3, match_t1};
endmodule
`default_nettype wire

// ==== bench/tca_cpu_model.sv ====
// Purpose: processor core model driving the byte I/O bus
// Assumes: strobes change at the falling clock edge
// Notes: tasks leave strobes up; idle drops them
`timescale 1ns/1ps
`default_nettype none
module tca_cpu_model (
  input wire logic core_clk_in,
  input wire logic [7:0] io_rdata_in,
  output logic [7:0] io_addr_out,
  output logic [7:0] io_wdata_out,
  output logic io_write_out,
  output logic io_read_out
);
  initial idle(0);
  // control c is never written, so its reserved bits stay zero
  task automatic idle(input int n);
    io_write_out = 1'b0;
    io_read_out = 1'b0;
    io_addr_out = 8'h00;
    io_wdata_out = 8'h00;
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_write_out = 1'b1;
    io_read_out = 1'b0;
    io_addr_out = a;
    io_wdata_out = d;
    @(negedge core_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    io_write_out = 1'b0;
    io_read_out = 1'b1;
    io_addr_out = a;
    @(negedge core_clk_in);
    q = io_rdata_in;
  endtask
  // high byte first, low byte commits
  task automatic wr16(input logic [7:0] h, input logic [7:0] l, input logic [15:0] v);
    wr(h, v[15:8]);
    wr(l, v[7:0]);
  endtask
endmodule
`default_nettype wire

// ==== bench/tca_access_props.sv ====
// Purpose: checker on the access block ports
// Assumes: one clock, synchronous reset
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module tca_access_props
  import tca_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_write_in,
  input wire logic io_read_in,
  input wire logic [NUM_TIMERS-1:0] tick_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic [7:0] match_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence pair_s(h, l);
    io_write_in && io_addr_in == h ##1 io_write_in && io_addr_in == l;
  endsequence
  sequence rd_s(a);
    io_read_in && io_addr_in == a;
  endsequence
  t1a_high_a: assert property (pair_s(8'h89, 8'h88) ##1 rd_s(8'h89)
    |=> io_rdata_out == $past(io_wdata_in, 3)) else $error("t1a high readback");
  t1a_low_a: assert property (pair_s(8'h89, 8'h88) ##1 rd_s(8'h88)
    |=> io_rdata_out == $past(io_wdata_in, 2)) else $error("t1a low readback");
  t4b_high_a: assert property (pair_s(8'hAA, 8'hAB) ##1 rd_s(8'hAA)
    |=> io_rdata_out == $past(io_wdata_in, 3)) else $error("t4b high readback");
  shared_latch_a: assert property (pair_s(8'hAA, 8'h88) ##1 rd_s(8'h89)
    |=> io_rdata_out == $past(io_wdata_in, 3)) else $error("latch not shared");
  counter_rw_a: assert property (pair_s(8'h85, 8'h84) ##1 rd_s(8'h84)
    |=> io_rdata_out == $past(io_wdata_in, 2)) else $error("counter readback");
  counter_latch_a: assert property (pair_s(8'h85, 8'h84) ##1 rd_s(8'h84) ##1 rd_s(8'h85)
    |=> io_rdata_out == $past(io_wdata_in, 4)) else $error("counter high latch");
  write_block_a: assert property (io_write_in && io_addr_in == 8'h84 ##1 tick_in[0]
    |=> match_out[2:0] == 3'b000) else $error("match after counter load");
  rdata_hold_a: assert property (!io_read_in |=> $stable(io_rdata_out))
    else $error("read data moved");
endmodule
bind tca_access tca_access_props u_props (.core_clk_in, .reset_in, .io_addr_in, .io_wdata_in,
  .io_write_in, .io_read_in, .tick_in, .io_rdata_out, .match_out);
`default_nettype wire

// ==== bench/timer16_counter_compare_access_bench.sv ====
// Purpose: register level tests of the access block
// Assumes: inputs change at the falling edge
// Notes: cpu model drives the bus, bench drives ticks
`timescale 1ns/1ps
`default_nettype none
module timer16_counter_compare_access_bench
  import tca_pkg::*;
;
  logic core_clk_in, reset_in, io_write_in, io_read_in, sw;
  logic [7:0] io_addr_in, io_wdata_in, io_rdata_out, match_out, q, m, lo, hi;
  logic [2:0] tick_in;
  logic [15:0] v;
  int fails, check_count;
  tca_cpu_model u_cpu (.core_clk_in, .io_rdata_in(io_rdata_out), .io_addr_out(io_addr_in),
    .io_wdata_out(io_wdata_in), .io_write_out(io_write_in), .io_read_out(io_read_in));
  tca_access u_dut (.core_clk_in, .reset_in, .io_addr_in, .io_wdata_in, .io_write_in,
    .io_read_in, .tick_in, .io_rdata_out, .match_out);
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tk(input int t);
    tick_in = 3'(1 << t);
    @(negedge core_clk_in);
    m = match_out;
    tick_in = 3'b000;
    @(negedge core_clk_in);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
  initial begin
    reset_in = 1'b1;
    tick_in = 3'b000;
    repeat (12) @(negedge core_clk_in);
    reset_in = 1'b0;
    for (int g = 0; g < 3; g++) begin
      for (int k = 0; k < 6 - 2 * (g / 2); k++) begin
        u_cpu.rd(8'(8'h88 + 16 * g + k), q);
        chk("compare reset", 8'h00, q);
      end
    end
    u_cpu.rd(8'h00, q);
    chk("unmapped", UNMAPPED_READ, q);
    u_cpu.rd(ADDR_COUNTER_T1_LOW, q);
    chk("counter reset", COUNTER_RESET[7:0], q);
    chk("match reset", 8'h00, match_out);
    $display("reset test done");
    for (int g = 0; g < 3; g++) begin
      for (int p = 0; p < 3 - g / 2; p++) begin
        sw = (g == 2 && p == 1);
        lo = 8'(8'h88 + 16 * g + 2 * p);
        hi = lo + {7'b0, !sw};
        lo = lo + {7'b0, sw};
        v = 16'(16'hA1B2 + 16'h1111 * (3 * g + p));
        u_cpu.wr16(hi, lo, v);
        u_cpu.rd(hi, q);
        chk("compare high", v[15:8], q);
        u_cpu.wr16(hi, lo, v);
        u_cpu.rd(lo, q);
        chk("compare low", v[7:0], q);
      end
    end
    u_cpu.wr16(8'hAA, 8'h88, 16'h5A77);
    u_cpu.rd(8'h89, q);
    chk("shared latch", 8'h5A, q);
    $display("compare test done");
    u_cpu.wr16(8'h85, 8'h84, 16'hABCD);
    u_cpu.rd(8'h84, q);
    chk("counter low", 8'hCD, q);
    u_cpu.rd(8'h85, q);
    chk("counter high", 8'hAB, q);
    u_cpu.wr16(8'h95, 8'h94, 16'h12FF);
    u_cpu.rd(8'h94, q);
    u_cpu.idle(0);
    tk(1);
    u_cpu.rd(8'h95, q);
    chk("latched high", 8'h12, q);
    $display("counter test done");
    for (int t = 0; t < 3; t++) begin
      u_cpu.wr16(8'(8'h89 + 16 * t), 8'(8'h88 + 16 * t), 16'h0005);
      u_cpu.wr16(8'(8'h85 + 16 * t), 8'(8'h84 + 16 * t), 16'h0005);
      u_cpu.idle(0);
      tk(t);
      chk("match after load", 8'h00, m);
      u_cpu.wr16(8'(8'h85 + 16 * t), 8'(8'h84 + 16 * t), 16'h0004);
      u_cpu.idle(0);
      tk(t);
      tk(t);
      chk("match", 8'(8'h01 << (3 * t)), m);
    end
    $display("match test done");
    print_verdict();
  end
endmodule
`default_nettype wire
